// >>> bench/plc_model.sv
/*
 Controller model: AHB-Lite master that issues single word transfers to the sequencer.
 Assumes one zero-wait slave whose hreadyout is fed back as hready.
*/
module plc_model (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic      [31:0] haddr,
   output logic      [1:0]  htrans,
   output logic             hwrite,
   output logic      [2:0]  hsize,
   output logic      [31:0] hwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata} = '0;
      hsize = 3'h2;
   end
   // The master waits on hready, since it may not rely on the zero-wait answer.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
      hwdata <= ~d;
   endtask : xfer
endmodule : plc_model

// >>> bench/tb_top.sv
/*
 Self-checking bench of the motion-set sequencer: guiding rows, status mirrors, moves,
 mark search with offset, reversal fault with acknowledge, and homing.
 Assumes the sequencer's register map and a 100 MHz clock.
*/
`include "motion_set_cfg.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'b0, hresetn = 1'b0, hsel, hwrite, hready, hresp;
   logic [31:0] haddr, hwdata, hrdata, r, m, q;
   logic [1:0] htrans;
   logic [2:0] hsize, flags;
   logic en = 1'b0, stp = 1'b1, jp = 1'b0, jm = 1'b0, mk = 1'b0, pwr, nf, att, op;
   logic [31:0] tix [10] = '{32'h200, 32'h300, 32'h002, 32'h102, 32'h202, 32'h302,
                             32'h402, 32'h003, 32'h103, 32'h403};
   logic [31:0] tdt [10] = '{32'h004, 32'h004, 32'h804, 32'd200, 32'h004, 32'h004,
                             32'h064, 32'h047, 32'h008, 32'h064};
   int n_fail = 0, samples_checked = 0;
   logic [31:0] rc [5] = '{32'h002, 32'h002, 32'h000, 32'h800, 32'h800};
   logic re [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
   logic rp [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
   initial forever #5 hclk = ~hclk;
   motion_set_sequencer motion_set_sequencer_inst (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
      .enable_ack_input(en), .stop_release_input(stp), .jog_plus_input(jp),
      .jog_minus_input(jm), .mark_sense_input(mk), .power_stage_enable(pwr),
      .no_fault_output(nf), .target_attained_output(att),
      .operation_enabled_output(op), .programmable_flags(flags));
   plc_model plc_model_inst (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      plc_model_inst.xfer(1'b1, a, d, x);
   endtask : wr
   task automatic pulse(input int gap);
      @(posedge hclk) mk <= 1'b1;
      @(posedge hclk) mk <= 1'b0;
      repeat (gap) @(posedge hclk);
   endtask : pulse
   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   initial begin
      #20000 n_fail++;
      conclude();
   end
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      chk({hready, pwr, nf, att, op, flags, hresp}, 9'h100);
      for (int i = 0; i < 5; i++) begin
         wr(`OFS_CTRL1, rc[i]);
         @(posedge hclk) en <= re[i];
         repeat (4) @(posedge hclk);
         chk(pwr, rp[i]);
      end
      @(posedge hclk) en <= 1'b1;
      wr(`OFS_CTRL1, 32'h002);
      repeat (3) @(posedge hclk);
      plc_model_inst.xfer(1'b0, `OFS_STAT1, 32'h0, r);
      chk({nf, att, op}, {r[3], r[10], r[1] & r[3]});
      // relative set 1, flags force 1, force 0, keep.
      wr(`OFS_TBL_INDEX, 32'h001);
      wr(`OFS_TBL_DATA, 32'h182);
      for (int w = 1; w < 5; w++) begin
         wr(`OFS_TBL_INDEX, {21'h0, w[2:0], 8'h01});
         wr(`OFS_TBL_DATA, (w == 1) ? 32'd20 : (w == 4) ? 32'd100 : 32'd4);
      end
      wr(`OFS_CTRL2, 32'h1);
      // start edge on control bit 4.
      wr(`OFS_CTRL1, 32'h012);
      for (int k = 0; k < 200 && att !== 1'b1; k++) @(posedge hclk);
      repeat (3) @(posedge hclk);
      chk(att, 1'b1);
      chk(flags, 3'b001);
      plc_model_inst.xfer(1'b0, `OFS_POS, 32'h0, r);
      chk(r, 32'd20);
      @(posedge hclk) jp <= 1'b1;
      repeat (10) @(posedge hclk);
      plc_model_inst.xfer(1'b0, `OFS_POS, 32'h0, r);
      chk(r, 32'd20);
      // jog acts without guiding; stop input gates motion.
      wr(`OFS_CTRL1, 32'h800);
      repeat (10) @(posedge hclk);
      plc_model_inst.xfer(1'b0, `OFS_POS, 32'h0, r);
      chk(($signed(r) > 32'sd20), 1'b1);
      @(posedge hclk) stp <= 1'b0;
      repeat (4) @(posedge hclk);
      plc_model_inst.xfer(1'b0, `OFS_POS, 32'h0, r);
      repeat (6) @(posedge hclk);
      plc_model_inst.xfer(1'b0, `OFS_POS, 32'h0, q);
      chk(q, r);
      // search set 2 chained to offset set 3; the zone covers the first mark.
      @(posedge hclk) begin
         jp  <= 1'b0;
         stp <= 1'b1;
      end
      wr(`OFS_CTRL1, 32'h002);
      wr(`OFS_IGN_BEGIN, r);
      wr(`OFS_IGN_END, r + 32'd40);
      for (int w = 0; w < 10; w++) begin
         wr(`OFS_TBL_INDEX, tix[w]);
         wr(`OFS_TBL_DATA, tdt[w]);
      end
      wr(`OFS_CTRL2, 32'h2);
      wr(`OFS_CTRL1, 32'h012);
      repeat (4) @(posedge hclk);
      pulse(12);
      pulse(0);
      for (int k = 0; k < 200 && att !== 1'b1; k++) @(posedge hclk);
      repeat (3) @(posedge hclk);
      plc_model_inst.xfer(1'b0, `OFS_MARK_POS, 32'h0, m);
      chk($signed(m) > $signed(r + 32'd40), 1'b1);
      chk(m, r + 32'd72);
      plc_model_inst.xfer(1'b0, `OFS_POS, 32'h0, q);
      chk(q, m + 32'd8);
      plc_model_inst.xfer(1'b0, `OFS_STAT1, 32'h0, q);
      chk({q[15], q[9]}, 2'b11);
      chk(flags, 3'b100);
      // offset against travel; the input edge must not acknowledge while guided.
      wr(`OFS_TBL_INDEX, 32'h103);
      wr(`OFS_TBL_DATA, 32'hffff_fff8);
      wr(`OFS_CTRL1, 32'h002);
      wr(`OFS_CTRL1, 32'h012);
      repeat (4) @(posedge hclk);
      pulse(4);
      chk(nf, 1'b0);
      @(posedge hclk) en <= 1'b0;
      repeat (3) @(posedge hclk);
      @(posedge hclk) en <= 1'b1;
      repeat (4) @(posedge hclk);
      chk(nf, 1'b0);
      wr(`OFS_CTRL1, 32'h082);
      repeat (4) @(posedge hclk);
      chk(nf, 1'b1);
      // start at set address 0 homes to position zero.
      wr(`OFS_CTRL2, 32'h0);
      wr(`OFS_CTRL1, 32'h012);
      repeat (3) @(posedge hclk);
      for (int k = 0; k < 200 && att !== 1'b1; k++) @(posedge hclk);
      repeat (2) @(posedge hclk);
      plc_model_inst.xfer(1'b0, `OFS_POS, 32'h0, q);
      chk(q, 32'h0);
      chk(att, 1'b1);
      conclude();
   end
endmodule : tb_top

// >>> src/motion_set_cfg.svh
/*
 Register offsets, field positions, table sizes and step constants of the motion-set sequencer.
 Assumes inclusion by bare name from the bench and from the sequencer module.
*/
`ifndef MOTION_SET_CFG_SVH
`define MOTION_SET_CFG_SVH
`define OFS_CTRL1     8'h00
`define OFS_CTRL2     8'h04
`define OFS_STAT1     8'h08
`define OFS_STAT2     8'h0c
`define OFS_POS       8'h10
`define OFS_MARK_POS  8'h14
`define OFS_IGN_BEGIN 8'h18
`define OFS_IGN_END   8'h1c
`define OFS_MOD_DIST  8'h20
`define OFS_OPTIONS   8'h24
`define OFS_TBL_INDEX 8'h28
`define OFS_TBL_DATA  8'h2c
`define C1_ENABLE     1
`define C1_START      4
`define C1_CHANGE     5
`define C1_ACK        7
`define C1_NO_GUIDE   11
`define S1_POWER      1
`define S1_OP_EN      2
`define S1_NO_FAULT   3
`define S1_REACHED    9
`define S1_ATTAINED   10
`define S1_MARK       15
`define S2_FLAGS_LO   12
`define OPT_HIGH_DEC  0
`define OPT_AUTO_POS  1
`define OPT_TEST_MOVE 2
`define TW_CTRL       3'h0
`define TW_TARGET     3'h1
`define TW_SPEED      3'h2
`define TW_ACCEL      3'h3
`define TW_DECEL      3'h4
`define TW_JERK       3'h5
`define TW_COUNT      6
`define TBL_SETS      32
`define TBL_WORDS     192
`define JOG_STEP      32'sh0000_0004
`endif

// >>> src/motion_set_pkg.sv
/*
 Types of the motion-set sequencer: set functions, direction modes and engine states.
 Assumes the constants header alongside it.
*/
package motion_set_pkg;
   typedef enum logic [2:0] {
      F_EMPTY = 3'b000, F_ABS = 3'b001, F_REL = 3'b010, F_GEAR = 3'b011,
      F_SEARCH = 3'b100, F_VEL = 3'b101, F_STOP = 3'b110, F_OFFSET = 3'b111
   } func_t;
   typedef enum logic [2:0] {
      DIR_ALL = 3'b000, DIR_POS = 3'b001, DIR_SHORT = 3'b010, DIR_NEG = 3'b011,
      DIR_KEEP = 3'b100
   } dir_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_HOME = 3'b001, ST_POSN = 3'b010, ST_SEARCH = 3'b011,
      ST_OFFSET = 3'b100, ST_RUN = 3'b101, ST_STOP = 3'b110
   } state_t;
endpackage : motion_set_pkg

// >>> src/motion_set_sequencer.sv
/*
 Motion-set sequencer: AHB-Lite register slave, set table, guiding and I/O gating,
 a simple step-per-cycle position engine, mark search with offset move and status flags.
 Assumes a single 100 MHz clock, inputs already synchronous, and one AHB-Lite master.
*/
// The register addresses and register access over AHB-Lite were left to the implementer.
`include "motion_set_cfg.svh"
module motion_set_sequencer
   import motion_set_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        enable_ack_input,
   input  wire logic        stop_release_input,
   input  wire logic        jog_plus_input,
   input  wire logic        jog_minus_input,
   input  wire logic        mark_sense_input,
   output logic             power_stage_enable,
   output logic             no_fault_output,
   output logic             target_attained_output,
   output logic             operation_enabled_output,
   output logic      [2:0]  programmable_flags
);
   logic        [7:0]  addr_q;
   logic               wr_q;
   logic        [31:0] ctrl1_q, ctrl2_q, opt_q, hrdata_q;
   logic signed [31:0] ign_b_q, ign_e_q, mod_q;
   logic        [4:0]  tset_q;
   logic        [2:0]  tword_q;
   logic        [31:0] tbl_q [0:`TBL_WORDS-1];
   logic               start_q, ack_q, en_prev_q, mark_prev_q;
   logic               power_q, fault_q, err_q, done_q;
   logic        [5:0]  done_pat_q;
   logic        [2:0]  flags_q;
   state_t             state_q;
   logic signed [31:0] pos_q, vel_q, rem_q, mark_pos_q;
   logic        [31:0] spd_q, acc_q, dec_q;
   logic               run_neg_q, attained_q, mark_det_q, auto_q;
   logic        [4:0]  set_q;
   logic        [5:0]  pat_q;
   logic        [31:0] stat1, stat2, rd_mux;
   logic        [7:0]  tidx, lidx, oidx;
   logic               guided, op_en, stop_hold, bus_wr, hit, launch, mark_hit;
   logic        [4:0]  lset;
   func_t              lfunc;
   logic signed [31:0] ltgt, lrem, step, pos_n, bpos, off_rem;
   logic        [31:0] vmag, rmag, smag;
   logic        [63:0] vv, need;
   logic               rev_err, dec_err;

   function automatic logic [31:0] mag(input logic signed [31:0] v);
      mag = v[31] ? 32'(-v) : 32'(v);
   endfunction : mag

   // Distance from the braking position to a modulo target under the chosen mode.
   function automatic logic signed [31:0] mod_dist(input logic signed [31:0] tgt,
                                                   input logic signed [31:0] bp,
                                                   input logic signed [31:0] m,
                                                   input dir_t md, input logic neg);
      logic signed [31:0] dp, dn;
      dp = tgt - bp;
      if (dp < 0) begin
         dp = dp + m;
      end
      dn = (dp == 0) ? 32'sh0 : dp - m;
      case (md)
         DIR_POS:   mod_dist = dp;
         DIR_NEG:   mod_dist = dn;
         DIR_SHORT: mod_dist = (dp <= (m >>> 1)) ? dp : dn;
         DIR_KEEP:  mod_dist = neg ? dn : dp;
         default:   mod_dist = tgt - bp;
      endcase
   endfunction : mod_dist

   assign guided = ~ctrl1_q[`C1_NO_GUIDE];
   assign op_en  = power_q & ~fault_q;
   assign stop_hold = ~stop_release_input;
   assign bus_wr = wr_q;
   assign hit    = hsel & hready & htrans[1];
   assign tidx   = 8'({3'h0, tset_q} * 8'd6) + 8'({5'h0, tword_q});
   assign stat1 = ({31'h0, power_q} << `S1_POWER)
                | ({31'h0, op_en} << `S1_OP_EN) | ({31'h0, ~fault_q} << `S1_NO_FAULT)
                | ({31'h0, attained_q} << `S1_REACHED)
                | ({31'h0, attained_q} << `S1_ATTAINED)
                | ({31'h0, mark_det_q} << `S1_MARK);
   assign stat2 = ({29'h0, flags_q} << `S2_FLAGS_LO) | {27'h0, set_q};

   always_comb begin
      case (haddr[7:0])
         `OFS_CTRL1:     rd_mux = ctrl1_q;
         `OFS_CTRL2:     rd_mux = ctrl2_q;
         `OFS_STAT1:     rd_mux = stat1;
         `OFS_STAT2:     rd_mux = stat2;
         `OFS_POS:       rd_mux = pos_q;
         `OFS_MARK_POS:  rd_mux = mark_pos_q;
         `OFS_IGN_BEGIN: rd_mux = ign_b_q;
         `OFS_IGN_END:   rd_mux = ign_e_q;
         `OFS_MOD_DIST:  rd_mux = mod_q;
         `OFS_OPTIONS:   rd_mux = opt_q;
         `OFS_TBL_INDEX: rd_mux = {21'h0, tword_q, 3'h0, tset_q};
         `OFS_TBL_DATA:  rd_mux = (tword_q < 3'(`TW_COUNT)) ? tbl_q[tidx] : 32'h0;
         default:        rd_mux = 32'h0;
      endcase
   end

   // Zero-wait slave; read data is registered in the address phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q   <= 8'h00;
         wr_q     <= 1'b0;
         hrdata_q <= 32'h0;
      end else begin
         wr_q <= hit & hwrite;
         if (hit) begin
            addr_q <= haddr[7:0];
         end
         if (hit && !hwrite) begin
            hrdata_q <= rd_mux;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl1_q <= 32'h0;
         ctrl2_q <= 32'h0;
         opt_q   <= 32'h0;
         ign_b_q <= 32'sh0;
         ign_e_q <= 32'sh0;
         mod_q   <= 32'sh0;
         tset_q  <= 5'h00;
         tword_q <= 3'h0;
         start_q <= 1'b0;
         ack_q   <= 1'b0;
      end else begin
         start_q <= bus_wr && addr_q == `OFS_CTRL1 && hwdata[`C1_START]
                    && !ctrl1_q[`C1_START] && !hwdata[`C1_NO_GUIDE];
         ack_q   <= bus_wr && addr_q == `OFS_CTRL1 && hwdata[`C1_ACK]
                    && !ctrl1_q[`C1_ACK] && !hwdata[`C1_NO_GUIDE];
         if (bus_wr) begin
            case (addr_q)
               `OFS_CTRL1:     ctrl1_q <= hwdata;
               `OFS_CTRL2:     ctrl2_q <= hwdata;
               `OFS_IGN_BEGIN: ign_b_q <= hwdata;
               `OFS_IGN_END:   ign_e_q <= hwdata;
               `OFS_MOD_DIST:  mod_q   <= hwdata;
               `OFS_OPTIONS:   opt_q   <= hwdata;
               `OFS_TBL_INDEX: begin
                  tset_q  <= hwdata[4:0];
                  tword_q <= hwdata[10:8];
               end
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < `TBL_WORDS; i++) begin
            tbl_q[i] <= 32'h0;
         end
      end else if (bus_wr && addr_q == `OFS_TBL_DATA && tword_q < 3'(`TW_COUNT)) begin
         tbl_q[tidx] <= hwdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         power_q     <= 1'b0;
         fault_q     <= 1'b0;
         en_prev_q   <= 1'b0;
         mark_prev_q <= 1'b0;
      end else begin
         en_prev_q   <= enable_ack_input;
         mark_prev_q <= mark_sense_input;
         power_q <= enable_ack_input & (~guided | ctrl1_q[`C1_ENABLE]);
         if (err_q) begin
            fault_q <= 1'b1;
         end else if (guided ? ack_q : (enable_ack_input & ~en_prev_q)) begin
            fault_q <= 1'b0;
         end
      end
   end

   // Launch decode; auto positioning after homing reuses set 0 as an absolute move.
   assign lset  = auto_q ? 5'h00 : ctrl2_q[4:0];
   assign lidx  = 8'({3'h0, lset} * 8'd6);
   assign lfunc = func_t'(tbl_q[lidx][2:0]);
   assign ltgt  = tbl_q[lidx + 8'(`TW_TARGET)];
   assign bpos = pos_q + vel_q;
   always_comb begin
      lrem = ltgt;
      if ((lfunc == F_ABS || auto_q) && mod_q > 0 && ltgt >= 0 && ltgt < mod_q
          && !opt_q[`OPT_TEST_MOVE] && !auto_q) begin
         lrem = vel_q + mod_dist(ltgt, (bpos >= mod_q) ? bpos - mod_q
                                 : (bpos < 0) ? bpos + mod_q : bpos, mod_q,
                                 dir_t'(tbl_q[lidx][5:3]), vel_q < 0);
      end else if (lfunc == F_ABS || auto_q) begin
         lrem = ltgt - pos_q;
      end else if (lset == 5'h00) begin
         lrem = -pos_q;
      end
   end
   assign launch = start_q && op_en && !stop_hold && (lset == 5'h00 || lfunc != F_EMPTY)
                   && (state_q == ST_IDLE || (ctrl1_q[`C1_CHANGE] && lset != 5'h00
                   && state_q != ST_STOP && state_q != ST_HOME));

   always_comb begin
      vmag = mag(vel_q);
      rmag = mag(rem_q);
      smag = vmag + acc_q;
      if (smag > spd_q) begin
         smag = spd_q;
      end
      step = 32'sh0;
      case (state_q)
         ST_HOME, ST_POSN, ST_SEARCH, ST_OFFSET: begin
            if (smag > rmag) begin
               smag = rmag;
            end
            step = rem_q[31] ? -$signed(smag) : $signed(smag);
         end
         ST_RUN: step = run_neg_q ? -$signed(smag) : $signed(smag);
         ST_STOP: begin
            smag = (vmag > dec_q) ? vmag - dec_q : 32'h0;
            step = vel_q[31] ? -$signed(smag) : $signed(smag);
         end
         default: begin
            if (!guided && op_en && !stop_hold && (jog_plus_input ^ jog_minus_input)) begin
               step = jog_plus_input ? `JOG_STEP : -`JOG_STEP;
            end
         end
      endcase
      pos_n = pos_q + step;
      if (mod_q > 0 && pos_n >= mod_q) begin
         pos_n = pos_n - mod_q;
      end else if (mod_q > 0 && pos_n < 0) begin
         pos_n = pos_n + mod_q;
      end
   end

   assign mark_hit = state_q == ST_SEARCH && mark_sense_input && !mark_prev_q
                     && !(pos_q >= ign_b_q && pos_q <= ign_e_q);
   assign oidx    = 8'({3'h0, set_q + 5'h01} * 8'd6);
   assign off_rem = $signed(tbl_q[oidx + 8'(`TW_TARGET)]) - step;
   assign rev_err = off_rem != 0 && (off_rem[31] != step[31] || step == 0);
   assign vv      = 64'(vmag[30:0]) * 64'(vmag[30:0]);
   assign need    = 64'(tbl_q[oidx + 8'(`TW_DECEL)][30:0]) * 64'(mag(off_rem)) * 64'd2;
   assign dec_err = vv > need && !opt_q[`OPT_HIGH_DEC];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= ST_IDLE;
         pos_q <= 32'sh0; vel_q <= 32'sh0; rem_q <= 32'sh0; mark_pos_q <= 32'sh0;
         spd_q <= 32'h0; acc_q <= 32'h0; dec_q <= 32'h0;
         run_neg_q <= 1'b0; attained_q <= 1'b0; mark_det_q <= 1'b0; auto_q <= 1'b0;
         set_q <= 5'h00; pat_q <= 6'h00; done_q <= 1'b0; done_pat_q <= 6'h00;
         err_q <= 1'b0;
      end else begin
         pos_q  <= pos_n;
         vel_q  <= step;
         rem_q  <= rem_q - step;
         done_q <= 1'b0;
         err_q  <= 1'b0;
         if (!op_en) begin
            state_q <= ST_IDLE;
            vel_q   <= 32'sh0;
            auto_q  <= 1'b0;
         end else if (launch || (auto_q && state_q == ST_IDLE)) begin
            set_q      <= lset;
            pat_q      <= tbl_q[lidx][11:6];
            spd_q      <= mag(tbl_q[lidx + 8'(`TW_SPEED)]);
            run_neg_q  <= tbl_q[lidx + 8'(`TW_SPEED)][31];
            acc_q      <= tbl_q[lidx + 8'(`TW_ACCEL)];
            dec_q      <= tbl_q[lidx + 8'(`TW_DECEL)];
            rem_q      <= lrem;
            attained_q <= 1'b0;
            mark_det_q <= 1'b0;
            auto_q     <= 1'b0;
            if (lset == 5'h00 && !auto_q) begin
               state_q <= ST_HOME;
            end else begin
               case (lfunc)
                  F_SEARCH:     state_q <= ST_SEARCH;
                  F_VEL, F_GEAR: state_q <= ST_RUN;
                  F_STOP:       state_q <= ST_STOP;
                  default:      state_q <= ST_POSN;
               endcase
            end
         end else if (stop_hold && state_q != ST_IDLE && state_q != ST_STOP) begin
            state_q <= ST_STOP;
         end else begin
            case (state_q)
               ST_HOME: begin
                  if (rem_q == step) begin
                     state_q <= ST_IDLE;
                     auto_q  <= opt_q[`OPT_AUTO_POS];
                     attained_q <= ~opt_q[`OPT_AUTO_POS];
                  end
               end
               ST_SEARCH: begin
                  if (mark_hit) begin
                     mark_pos_q <= pos_q;
                     mark_det_q <= 1'b1;
                     done_q     <= 1'b1;
                     done_pat_q <= pat_q;
                     set_q      <= set_q + 5'h01;
                     pat_q      <= tbl_q[oidx][11:6];
                     rem_q      <= off_rem;
                     if (rev_err || dec_err) begin
                        err_q   <= 1'b1;
                        state_q <= ST_STOP;
                     end else begin
                        state_q <= ST_OFFSET;
                     end
                  end else if (rem_q == step) begin
                     state_q <= ST_IDLE; attained_q <= 1'b1;
                     done_q  <= 1'b1; done_pat_q <= pat_q;
                  end
               end
               ST_POSN, ST_OFFSET: begin
                  if (rem_q == step) begin
                     state_q <= ST_IDLE; attained_q <= 1'b1;
                     done_q  <= 1'b1; done_pat_q <= pat_q;
                  end
               end
               ST_RUN: begin
                  if (smag == spd_q && !attained_q) begin
                     attained_q <= 1'b1; done_q <= 1'b1; done_pat_q <= pat_q;
                  end
               end
               ST_STOP: begin
                  if (step == 0) begin
                     state_q <= ST_IDLE; attained_q <= 1'b1;
                     done_q  <= 1'b1; done_pat_q <= pat_q;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_q <= 3'h0;
      end else if (done_q) begin
         for (int b = 0; b < 3; b++) begin
            if (done_pat_q[2*b +: 2] == 2'b01) begin
               flags_q[b] <= 1'b0;
            end else if (done_pat_q[2*b +: 2] == 2'b10) begin
               flags_q[b] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         no_fault_output          <= 1'b0;
         target_attained_output   <= 1'b0;
         operation_enabled_output <= 1'b0;
         power_stage_enable       <= 1'b0;
         programmable_flags       <= 3'h0;
      end else begin
         no_fault_output          <= stat1[`S1_NO_FAULT];
         target_attained_output   <= stat1[`S1_ATTAINED];
         operation_enabled_output <= op_en;
         power_stage_enable       <= power_q;
         programmable_flags       <= flags_q;
      end
   end

   assign hrdata    = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_home_req;
      start_q && op_en && !stop_hold && state_q == ST_IDLE && ctrl2_q[4:0] == 5'h00 && !auto_q;
   endsequence
   sequence s_mark_in_zone;
      state_q == ST_SEARCH && mark_sense_input && !mark_prev_q
      && pos_q >= ign_b_q && pos_q <= ign_e_q;
   endsequence
   property p_power_gate;
      guided && !(enable_ack_input && ctrl1_q[`C1_ENABLE]) |=> !power_q;
   endproperty
   a_power_gate: assert property (p_power_gate) else $error("power without enable");
   property p_ack_guided;
      guided && fault_q && !ack_q && !err_q |=> fault_q;
   endproperty
   a_ack_guided: assert property (p_ack_guided) else $error("fault cleared wrongly");
   property p_stop_hold;
      stop_hold && op_en && state_q != ST_IDLE |=> state_q inside {ST_STOP, ST_IDLE};
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop not held");
   property p_no_jog;
      guided && state_q == ST_IDLE |=> pos_q == $past(pos_q);
   endproperty
   a_no_jog: assert property (p_no_jog) else $error("jog while guided");
   property p_out_fault;
      $past(hresetn) |-> no_fault_output == $past(!fault_q);
   endproperty
   a_out_fault: assert property (p_out_fault) else $error("fault output mismatch");
   property p_out_attained;
      ##1 target_attained_output == $past(attained_q);
   endproperty
   a_out_attained: assert property (p_out_attained) else $error("target out mismatch");
   property p_home;
      s_home_req |=> state_q == ST_HOME;
   endproperty
   a_home: assert property (p_home) else $error("set 0 did not home");
   property p_ignore;
      s_mark_in_zone |=> !mark_det_q;
   endproperty
   a_ignore: assert property (p_ignore) else $error("mark in zone taken");
   property p_mark_latch;
      mark_hit && op_en && !stop_hold && !launch |=> mark_det_q && mark_pos_q == $past(pos_q);
   endproperty
   a_mark_latch: assert property (p_mark_latch) else $error("mark not latched");
   property p_err_fault;
      err_q |=> fault_q ##1 !no_fault_output;
   endproperty
   a_err_fault: assert property (p_err_fault) else $error("error not shown");
   property p_flags;
      done_q && done_pat_q[1:0] == 2'b10 |=> flags_q[0] ##1 programmable_flags[0];
   endproperty
   a_flags: assert property (p_flags) else $error("flag not set");
endmodule : motion_set_sequencer
